//--- ssp_top.sv
`timescale 1ns/100ps
//
// Contract
// - Serial clock is system clock over even prescale then one plus rate.
// - System clock at least 2x serial clock master, 12x slave.
// - Transmit FIFO of eight 16-bit words filled by data port writes.
// - Receive FIFO of eight 16-bit words emptied by data port reads.
// - Received bits collect in a shifter, then load the FIFO in parallel.
// - Four interrupt sources: tx service, rx service, timeout, overrun.
// - Enabled interrupt sources are ORed into one request line.
// - One mask bit per source; a 1 enables it.
// - Sources readable both raw and masked.
// - Word size 4 to 16 bits, most significant bit first.
// - Pulsed-frame, SPI and command-response formats are selectable.
// - Serial clock idles inactive, toggles only during a word.
// - Timeout when clock idle for the period and receive data waits.
// - SPI and command-response frame select is low for the frame.
// - Pulsed-frame select pulses one period; drive rising, latch falling.
// - Command-response sends 8 control bits, waits a clock, then receives.
// - Pulsed-frame idle: clock and select low, transmit line released.
// - Pulsed-frame start pulses select high and loads the shifter.
// - Pulsed-frame MSB goes out as the shifter loads, before the next rising edge.
// - Pulsed-frame samples on falling edges, then stores the word.
// - SPI idle clock level equals the clock polarity bit.
// - SPI captures on first edge for phase 0, second for phase 1.
// - SPI phase 0 raises select between back-to-back words.
// - SPI phase 1 keeps select low between back-to-back words.
// - SPI select returns high one period after the last capture.
//
module ssp_top #(
  parameter int FIFO_DEPTH = ssp_pkg::FIFO_DEPTH
) (
  // Clock, reset and clock enable
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  // Configuration
  input  wire logic        i_enable,
  input  wire logic        i_master,
  input  wire logic        i_loopback,
  input  wire logic [1:0]  i_format,
  input  wire logic        i_clock_polarity_bit,
  input  wire logic        i_clock_phase_bit,
  input  wire logic [3:0]  i_data_size,
  input  wire logic [7:0]  i_prescale_divisor,
  input  wire logic [7:0]  i_serial_clock_rate,
  input  wire logic [3:0]  i_interrupt_mask,
  // Data port, write side
  input  wire logic        i_tx_valid,
  input  wire logic [15:0] i_tx_data,
  output logic             o_tx_ready,
  // Data port, read side
  output logic             o_rx_valid,
  output logic [15:0]      o_rx_data,
  input  wire logic        i_rx_ready,
  // Status and interrupt
  input  wire logic        i_timeout_clear,
  input  wire logic        i_overrun_clear,
  output logic [3:0]       o_raw_interrupt_status,
  output logic [3:0]       o_masked_interrupt_status,
  output logic             o_irq,
  output logic             o_busy,
  // Serial pins
  input  wire logic        i_serial_clock,
  output logic             o_serial_clock,
  output logic             o_serial_clock_oe,
  input  wire logic        i_frame_select,
  output logic             o_frame_select,
  output logic             o_frame_select_oe,
  output logic             o_serial_transmit_line,
  output logic             o_serial_transmit_oe,
  input  wire logic        i_serial_receive_line
);

  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  if (FIFO_DEPTH < 2 || CW != ssp_pkg::COUNT_WIDTH) begin
    $error("ssp_top: bad FIFO_DEPTH");
  end

  // ------------------------------------------------------------------
  // Decoded configuration
  // ------------------------------------------------------------------
  logic       fmt_spi;
  logic       fmt_cmd;
  logic       fmt_pulsed;
  logic [3:0] size_m1;
  logic       cap_phase;
  logic       idle_clk;
  logic       idle_fss;
  logic [5:0] last_edge;

  assign fmt_spi    = i_format == ssp_pkg::FMT_SPI;
  assign fmt_cmd    = i_format == ssp_pkg::FMT_CMD;
  assign fmt_pulsed = ~fmt_spi & ~fmt_cmd;
  assign size_m1    = (i_data_size < ssp_pkg::MIN_SIZE_M1) ?
                      ssp_pkg::MIN_SIZE_M1 : i_data_size;
  // Capture edge parity: odd edges are the trailing ones.
  assign cap_phase  = fmt_spi ? i_clock_phase_bit : fmt_pulsed;
  assign idle_clk   = fmt_spi & i_clock_polarity_bit;
  assign idle_fss   = ~fmt_pulsed;
  assign last_edge  = (fmt_cmd ? ssp_pkg::CMD_RX_EDGE : 6'h00) +
                      {1'b0, size_m1, 1'b1};

  // ------------------------------------------------------------------
  // FIFOs
  // ------------------------------------------------------------------
  logic          txf_valid;
  logic [15:0]   txf_data;
  logic [CW-1:0] tx_count;
  logic [CW-1:0] rx_count;
  logic          rxf_ready;
  logic          load_ev;
  logic          push_ev;
  logic [15:0]   rx_sh;
  logic [15:0]   rx_word;

  ssp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .CW(CW)) u_tx_fifo (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_ce        (i_ce),
    .i_in_valid  (i_tx_valid),
    .i_in_data   (i_tx_data),
    .o_in_ready  (o_tx_ready),
    .o_out_valid (txf_valid),
    .o_out_data  (txf_data),
    .i_out_ready (load_ev),
    .o_count     (tx_count)
  );

  ssp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .CW(CW)) u_rx_fifo (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_ce        (i_ce),
    .i_in_valid  (push_ev),
    .i_in_data   (rx_word),
    .o_in_ready  (rxf_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_data),
    .i_out_ready (i_rx_ready),
    .o_count     (rx_count)
  );

  // ------------------------------------------------------------------
  // Bit-rate divider: half period is (divisor/2)*(1+rate) cycles
  // ------------------------------------------------------------------
  logic [6:0] pre_cnt;
  logic [7:0] rate_cnt;
  logic [6:0] pre_top;
  logic       pre_wrap;
  logic       tick;

  assign pre_top  = (i_prescale_divisor < ssp_pkg::MIN_PRESCALE) ?
                    7'h00 : i_prescale_divisor[7:1] - 7'h01;
  assign pre_wrap = pre_cnt >= pre_top;
  assign tick     = pre_wrap & (rate_cnt >= i_serial_clock_rate);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_cnt  <= '0;
      rate_cnt <= '0;
    end else if (i_ce) begin
      if (!i_enable || pre_wrap) begin
        pre_cnt <= '0;
      end else begin
        pre_cnt <= pre_cnt + 7'h01;
      end
      if (!i_enable || tick) begin
        rate_cnt <= '0;
      end else if (pre_wrap) begin
        rate_cnt <= rate_cnt + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // Slave pin synchronisers and edge detection
  // ------------------------------------------------------------------
  logic sclk_meta;
  logic sclk_s;
  logic sclk_d;
  logic fss_meta;
  logic fss_s;
  logic fss_d;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_meta <= 1'b0;
      sclk_s    <= 1'b0;
      sclk_d    <= 1'b0;
      fss_meta  <= 1'b1;
      fss_s     <= 1'b1;
      fss_d     <= 1'b1;
    end else if (i_ce) begin
      sclk_meta <= i_serial_clock;
      sclk_s    <= sclk_meta;
      sclk_d    <= sclk_s;
      fss_meta  <= i_frame_select;
      fss_s     <= fss_meta;
      fss_d     <= fss_s;
    end
  end

  // ------------------------------------------------------------------
  // Master sequencer
  // ------------------------------------------------------------------
  ssp_pkg::ssp_state_type state;
  logic [5:0] edge_cnt;
  logic       more;
  logic       m_start;
  logic       m_cap;
  logic       m_shf;
  logic       m_on;

  assign m_on    = i_enable & i_master;
  assign more    = txf_valid & ~(fmt_spi & ~i_clock_phase_bit);
  assign m_start = m_on & tick & txf_valid &
                   (state == ssp_pkg::S_IDLE ||
                    (state == ssp_pkg::S_TAIL &&
                     edge_cnt[0] == cap_phase && more));
  assign m_cap   = tick && state == ssp_pkg::S_SHIFT &&
                   edge_cnt[0] == cap_phase &&
                   (!fmt_cmd || edge_cnt >= ssp_pkg::CMD_RX_EDGE);
  assign m_shf   = tick && state == ssp_pkg::S_SHIFT &&
                   edge_cnt[0] != cap_phase && edge_cnt != 6'h00 &&
                   (!fmt_cmd || edge_cnt < ssp_pkg::CMD_TX_EDGES);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state          <= ssp_pkg::S_IDLE;
      edge_cnt       <= '0;
      o_serial_clock <= 1'b0;
      o_frame_select <= 1'b0;
    end else if (i_ce) begin
      case (state)
        ssp_pkg::S_IDLE: begin
          o_serial_clock <= idle_clk;
          o_frame_select <= idle_fss;
          edge_cnt       <= '0;
          if (m_start) begin
            state          <= ssp_pkg::S_LEAD;
            o_frame_select <= fmt_pulsed;
          end
        end
        ssp_pkg::S_LEAD: begin
          if (tick) begin
            o_serial_clock <= o_serial_clock ^ fmt_pulsed;
            edge_cnt       <= edge_cnt + 6'h01;
            if (!fmt_pulsed || edge_cnt[0]) begin
              state          <= ssp_pkg::S_SHIFT;
              edge_cnt       <= '0;
              o_frame_select <= 1'b0;
            end
          end
        end
        ssp_pkg::S_SHIFT: begin
          if (tick) begin
            o_serial_clock <= ~o_serial_clock;
            edge_cnt       <= edge_cnt + 6'h01;
            if (edge_cnt == last_edge) begin
              state    <= ssp_pkg::S_TAIL;
              edge_cnt <= '0;
            end
          end
        end
        ssp_pkg::S_TAIL: begin
          if (tick) begin
            edge_cnt <= edge_cnt + 6'h01;
            if (m_start) begin
              state          <= ssp_pkg::S_LEAD;
              edge_cnt       <= '0;
              o_frame_select <= fmt_pulsed;
              if (!fmt_pulsed) begin
                state <= ssp_pkg::S_SHIFT;
              end
            end else if (edge_cnt[0] == cap_phase) begin
              state          <= ssp_pkg::S_IDLE;
              o_frame_select <= idle_fss;
            end
          end
        end
        default: begin
          state <= ssp_pkg::S_IDLE;
        end
      endcase
      if (!m_on) begin
        state <= ssp_pkg::S_IDLE;
      end
    end
  end

  // ------------------------------------------------------------------
  // Slave edge events
  // ------------------------------------------------------------------
  logic s_lead;
  logic s_trail;
  logic s_start;
  logic s_cap;
  logic s_shf;
  logic s_act;
  logic s_first;

  assign s_lead  = (sclk_s ^ sclk_d) & (sclk_s != idle_clk);
  assign s_trail = (sclk_s ^ sclk_d) & (sclk_s == idle_clk);
  assign s_start = fmt_pulsed ? (s_trail & fss_s) : (fss_d & ~fss_s);
  assign s_act   = fmt_pulsed | ~fss_s;
  assign s_cap   = s_act & ~s_start & (cap_phase ? s_trail : s_lead);
  assign s_shf   = s_act & ~s_first & (cap_phase ? s_lead : s_trail);

  // ------------------------------------------------------------------
  // Shared shift path
  // ------------------------------------------------------------------
  logic [15:0] tx_sh;
  logic [3:0]  cap_cnt;
  logic        cap_ev;
  logic        shf_ev;
  logic        s_on;
  logic        rx_bit;

  assign s_on    = i_enable & ~i_master;
  assign load_ev = m_start | (s_on & (s_start | (push_ev & ~fmt_pulsed)) &
                              txf_valid);
  assign cap_ev  = m_cap | (s_on & s_cap);
  assign shf_ev  = m_shf | (s_on & s_shf);
  assign rx_bit  = i_loopback ? tx_sh[15] : i_serial_receive_line;
  assign push_ev = cap_ev && cap_cnt == size_m1;
  assign rx_word = {rx_sh[14:0], rx_bit} & ~(16'hFFFE << size_m1);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_sh   <= '0;
      s_first <= 1'b1;
    end else if (i_ce) begin
      if (load_ev) begin
        tx_sh   <= fmt_cmd ? {txf_data[7:0], 8'h00} :
                   txf_data << (4'hF - size_m1);
        s_first <= 1'b1;
      end else if (shf_ev) begin
        tx_sh <= {tx_sh[14:0], 1'b0};
      end else if (state == ssp_pkg::S_IDLE && !s_act) begin
        tx_sh <= '0;
      end
      if (cap_ev && !load_ev) begin
        s_first <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_sh   <= '0;
      cap_cnt <= '0;
    end else if (i_ce) begin
      if (push_ev || load_ev || (s_on && s_start)) begin
        cap_cnt <= '0;
      end else if (cap_ev) begin
        cap_cnt <= cap_cnt + 4'h1;
      end
      if (cap_ev) begin
        rx_sh <= {rx_sh[14:0], rx_bit};
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin enables
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_serial_clock_oe    <= 1'b0;
      o_frame_select_oe    <= 1'b0;
      o_serial_transmit_oe <= 1'b0;
      o_busy               <= 1'b0;
    end else if (i_ce) begin
      o_serial_clock_oe    <= m_on;
      o_frame_select_oe    <= m_on;
      o_serial_transmit_oe <= m_on ?
        (!fmt_pulsed || state != ssp_pkg::S_IDLE) :
        (s_on && !fss_s && !fmt_pulsed);
      o_busy <= state != ssp_pkg::S_IDLE || txf_valid;
    end
  end

  assign o_serial_transmit_line = tx_sh[15];

  // ------------------------------------------------------------------
  // Receive timeout and overrun
  // ------------------------------------------------------------------
  logic [7:0] idle_cnt;
  logic       timeout;
  logic       overrun;
  logic       clk_moved;

  assign clk_moved = (m_on & tick & (state == ssp_pkg::S_SHIFT)) |
                     (s_on & (sclk_s ^ sclk_d));

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idle_cnt <= '0;
      timeout  <= 1'b0;
      overrun  <= 1'b0;
    end else if (i_ce) begin
      if (clk_moved || !o_rx_valid) begin
        idle_cnt <= '0;
      end else if (tick && idle_cnt != ssp_pkg::TIMEOUT_HALF_TICKS) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
      if (idle_cnt == ssp_pkg::TIMEOUT_HALF_TICKS && o_rx_valid) begin
        timeout <= 1'b1;
      end else if (i_timeout_clear) begin
        timeout <= 1'b0;
      end
      if (push_ev && !rxf_ready) begin
        overrun <= 1'b1;
      end else if (i_overrun_clear) begin
        overrun <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------------
  logic [3:0] raw;

  always_comb begin
    raw = 4'h0;
    raw[ssp_pkg::ST_TX_SERVICE] = tx_count <= ssp_pkg::TX_SERVICE_LEVEL;
    raw[ssp_pkg::ST_RX_SERVICE] = rx_count >= ssp_pkg::RX_SERVICE_LEVEL;
    raw[ssp_pkg::ST_RX_TIMEOUT] = timeout;
    raw[ssp_pkg::ST_RX_OVERRUN] = overrun;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_raw_interrupt_status    <= '0;
      o_masked_interrupt_status <= '0;
      o_irq                     <= 1'b0;
    end else if (i_ce) begin
      o_raw_interrupt_status    <= raw;
      o_masked_interrupt_status <= raw & i_interrupt_mask;
      o_irq <= |(raw & i_interrupt_mask);
    end
  end

endmodule // ssp_top

//--- ssp_pkg.sv
package ssp_pkg;

  // ----
  // Sizes
  // ----
  localparam int DATA_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int COUNT_WIDTH = 4;

  // ----
  // Frame formats
  // ----
  localparam logic [1:0] FMT_PULSED = 2'h0;
  localparam logic [1:0] FMT_SPI    = 2'h1;
  localparam logic [1:0] FMT_CMD    = 2'h2;

  // Smallest word size minus one (four bits).
  localparam logic [3:0] MIN_SIZE_M1 = 4'h3;

  // Command-response edges: eight control bits, then one idle clock.
  localparam logic [5:0] CMD_TX_EDGES = 6'h10;
  localparam logic [5:0] CMD_RX_EDGE  = 6'h12;

  // Smallest prescale divisor.
  localparam logic [7:0] MIN_PRESCALE = 8'h02;

  // ----
  // Interrupt sources
  // ----
  localparam int ST_TX_SERVICE = 0;
  localparam int ST_RX_SERVICE = 1;
  localparam int ST_RX_TIMEOUT = 2;
  localparam int ST_RX_OVERRUN = 3;
  localparam logic [COUNT_WIDTH-1:0] TX_SERVICE_LEVEL = 4'h4;
  localparam logic [COUNT_WIDTH-1:0] RX_SERVICE_LEVEL = 4'h4;

  // Timeout: 32 idle serial clock periods, counted in half periods.
  localparam logic [7:0] TIMEOUT_HALF_TICKS = 8'h40;

  // ----
  // Master sequencer
  // ----
  typedef enum logic [1:0] {
    S_IDLE,
    S_LEAD,
    S_SHIFT,
    S_TAIL
  } ssp_state_type;

endpackage

//--- ssp_fifo.sv
`timescale 1ns/100ps

module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int CW    = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_ce,
  // Filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Draining side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready,
  // Fill level
  output logic      [CW-1:0]    o_count
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || CW != AW + 1 || WIDTH < 1) begin
    $error("ssp_fifo: bad WIDTH, DEPTH or CW");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;
  logic [CW-1:0]    next_count;

  assign push = i_in_valid & o_in_ready;
  assign pop  = o_out_valid & i_out_ready;
  assign o_out_data = mem[rd_ptr];

  always_comb begin
    next_count = o_count;
    if (push & ~pop) begin
      next_count = o_count + 1'b1;
    end else if (pop & ~push) begin
      next_count = o_count - 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        mem[i] <= '0;
      end else if (i_ce && push && wr_ptr == AW'(i)) begin
        mem[i] <= i_in_data;
      end
    end
  end

  // ------------------------------------------------------------------
  // Pointers and flags
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      o_count     <= '0;
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      o_count     <= next_count;
      o_in_ready  <= next_count != CW'(DEPTH);
      o_out_valid <= next_count != '0;
    end
  end

endmodule // ssp_fifo

//--- ssp_checker.sv
`timescale 1ns/100ps
module ssp_checker (
  // Clock, reset and configuration
  input logic       i_clk,
  input logic       i_resetn,
  input logic       i_enable,
  input logic       i_master,
  input logic [1:0] i_format,
  input logic       i_clock_polarity_bit,
  input logic       i_clock_phase_bit,
  input logic [3:0] i_data_size,
  input logic [7:0] i_prescale_divisor,
  input logic [7:0] i_serial_clock_rate,
  input logic [3:0] i_interrupt_mask,
  // Observed outputs
  input logic [3:0] o_raw_interrupt_status,
  input logic [3:0] o_masked_interrupt_status,
  input logic       o_irq,
  input logic       o_busy,
  input logic       o_serial_clock,
  input logic       o_serial_clock_oe,
  input logic       o_frame_select,
  input logic       o_frame_select_oe,
  input logic       o_serial_transmit_oe
);
  // ----
  // Helper logic
  // ----
  logic [5:0] cfg_q;
  logic [1:0] quiet;
  logic [5:0] low_len;
  logic       alive;
  wire  [5:0] cfg = {i_enable, i_master, i_format, i_clock_polarity_bit,
                     i_clock_phase_bit};
  wire  [3:0] raw = o_raw_interrupt_status;
  wire  [3:0] msk = o_masked_interrupt_status;
  wire        en_m = i_enable && i_master;
  wire        calm = quiet == 2'h3 && en_m;
  wire        fast = calm && i_prescale_divisor == 8'h02
                     && i_serial_clock_rate == 8'h00;
  wire        spi = i_format == ssp_pkg::FMT_SPI;
  wire        pulsed = i_format == ssp_pkg::FMT_PULSED;
  wire  [5:0] spi_len = {1'b0, i_data_size, 1'b0} + 6'h04;

  // Counts settled cycles so mode changes never trip the checks.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q <= 6'h00;
      quiet <= 2'h0;
      alive <= 1'b0;
    end else begin
      cfg_q <= cfg;
      quiet <= (cfg != cfg_q) ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
      alive <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) low_len <= 6'h00;
    else if (o_frame_select) low_len <= 6'h00;
    else low_len <= low_len + 6'h01;
  end

  // ----
  // Assertions
  // ----
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_irq; $stable(msk) |-> o_irq == |msk; endproperty
  a_irq: assert property (p_irq) else $error("irq not OR of masked");
  property p_msk;
    ($stable(raw) && $stable(i_interrupt_mask)) [*2]
      |-> msk == (raw & i_interrupt_mask);
  endproperty
  a_msk: assert property (p_msk) else $error("bad masked status");
  property p_fs_oe; alive |-> o_frame_select_oe == $past(en_m); endproperty
  a_fs_oe: assert property (p_fs_oe) else $error("bad select enable");
  property p_ck_oe; alive |-> o_serial_clock_oe == $past(en_m); endproperty
  a_ck_oe: assert property (p_ck_oe) else $error("bad clock enable");
  property p_spi_idle;
    (calm && spi && !o_busy) [*2] |-> o_serial_clock == i_clock_polarity_bit;
  endproperty
  a_spi_idle: assert property (p_spi_idle) else $error("idle clock");
  property p_pls_idle;
    (calm && pulsed && !o_busy) [*2]
      |-> !(o_frame_select || o_serial_clock || o_serial_transmit_oe);
  endproperty
  a_pls_idle: assert property (p_pls_idle) else $error("pulsed idle");
  property p_pulse;
    fast && pulsed && $rose(o_frame_select)
      |-> ##1 o_frame_select ##1 !o_frame_select;
  endproperty
  a_pulse: assert property (p_pulse) else $error("select pulse length");
  property p_spi_len;
    fast && spi && !i_clock_phase_bit && $rose(o_frame_select)
      |-> low_len == spi_len;
  endproperty
  a_spi_len: assert property (p_spi_len) else $error("select low time");
  property p_fs_start;
    calm && spi && $fell(o_frame_select)
      |-> o_busy && o_serial_clock == i_clock_polarity_bit;
  endproperty
  a_fs_start: assert property (p_fs_start) else $error("frame start");

  cover property (fast && pulsed && $rose(o_frame_select));
  cover property (fast && spi && $rose(o_frame_select));
  cover property ($rose(raw[3]));
endmodule // ssp_checker

bind ssp_top ssp_checker chk_u (.*);

//--- ssp_spi_slave.sv
`timescale 1ns/100ps
module ssp_spi_slave (
  // Serial pins
  input  wire logic        i_sclk,
  input  wire logic        i_select_n,
  input  wire logic        i_mosi,
  output logic             o_miso,
  // Reply word, its size and the word captured
  input  wire logic [15:0] i_word,
  input  wire logic [3:0]  i_size,
  output logic      [15:0] o_got
);
  int bit_i = 0;
  initial o_miso = 1'b0;
  initial o_got = 16'h0000;
  always @(negedge i_select_n) begin
    bit_i = i_size;
    o_got = 16'h0000;
    o_miso = i_word[bit_i];
  end
  always @(posedge i_sclk) begin
    if (!i_select_n) o_got = {o_got[14:0], i_mosi};
  end
  always @(negedge i_sclk) begin
    if (!i_select_n && bit_i > 0) begin
      bit_i--;
      o_miso = i_word[bit_i];
    end
  end
  // A released line shows the inverse of its last value.
  always @(posedge i_select_n) o_miso = ~o_miso;
endmodule // ssp_spi_slave

//--- tb.sv
`timescale 1ns/100ps
module tb;
  // ----
  // Connections
  // ----
  logic        i_clk, i_resetn, i_ce, i_enable, i_master, i_loopback;
  logic [1:0]  i_format;
  logic        i_clock_polarity_bit, i_clock_phase_bit;
  logic [3:0]  i_data_size, i_interrupt_mask;
  logic [7:0]  i_prescale_divisor, i_serial_clock_rate;
  logic        i_tx_valid, o_tx_ready, o_rx_valid, i_rx_ready;
  logic [15:0] i_tx_data, o_rx_data, got;
  logic        i_timeout_clear, i_overrun_clear, o_irq, o_busy;
  logic [3:0]  o_raw_interrupt_status, o_masked_interrupt_status;
  logic        i_serial_clock, o_serial_clock, o_serial_clock_oe;
  logic        i_frame_select, o_frame_select, o_frame_select_oe;
  logic        o_serial_transmit_line, o_serial_transmit_oe;
  logic        i_serial_receive_line;
  int          bad_count = 0;
  int          total_checks = 0;

  ssp_top dut_u (.*);
  ssp_spi_slave part_u (
    .i_sclk     (o_serial_clock),
    .i_select_n (o_frame_select),
    .i_mosi     (o_serial_transmit_line),
    .o_miso     (i_serial_receive_line),
    .i_word     (16'h005A),
    .i_size     (i_data_size),
    .o_got      (got)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ----
  // Access tasks
  // ----
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    @(negedge i_clk);
    i_tx_valid = 1'b1;
    i_tx_data = d;
    for (int n = 0; n < 3000 && o_tx_ready !== 1'b1; n++) @(negedge i_clk);
    @(negedge i_clk);
    i_tx_valid = 1'b0;
  endtask
  task automatic rd(input logic [15:0] e);
    @(negedge i_clk);
    for (int n = 0; n < 3000 && o_rx_valid !== 1'b1; n++) @(negedge i_clk);
    chk(o_rx_data, e);
    i_rx_ready = 1'b1;
    @(negedge i_clk);
    i_rx_ready = 1'b0;
  endtask
  task automatic idle;
    repeat (2) @(negedge i_clk);
    for (int n = 0; n < 3000 && o_busy !== 1'b0; n++) @(negedge i_clk);
  endtask
  task automatic xfer(input logic [15:0] d, input logic [15:0] e);
    wr(d);
    rd(e);
    idle();
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #400000;
    bad_count++;
    final_report();
  end

  // ----
  // Tests
  // ----
  initial begin
    time t0;
    {i_ce, i_master, i_loopback, i_frame_select} = 4'hF;
    {i_resetn, i_enable, i_clock_polarity_bit, i_clock_phase_bit} = 4'h0;
    {i_tx_valid, i_rx_ready, i_timeout_clear, i_overrun_clear} = 4'h0;
    {i_serial_clock, i_format, i_data_size} = 7'h1F;
    {i_prescale_divisor, i_serial_clock_rate} = 16'h0200;
    {i_interrupt_mask, i_tx_data} = 20'h00000;
    repeat (20) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(16'(o_tx_ready), 16'h0001);
    chk(16'(o_raw_interrupt_status), 16'h0001);
    for (int k = 0; k < 8; k++) begin
      wr({4'(k), 12'hC3A});
    end
    chk(16'(o_tx_ready), 16'h0000);
    i_enable = 1'b1;
    wr(16'hFFFF);
    idle();
    chk({11'h000, o_raw_interrupt_status, o_irq}, 16'h0016);
    i_interrupt_mask = 4'h8;
    repeat (3) @(negedge i_clk);
    chk({11'h000, o_masked_interrupt_status, o_irq}, 16'h0011);
    i_overrun_clear = 1'b1;
    @(negedge i_clk);
    i_overrun_clear = 1'b0;
    repeat (80) @(negedge i_clk);
    chk({11'h000, o_raw_interrupt_status, o_irq}, 16'h000E);
    for (int k = 0; k < 8; k++) begin
      rd({4'(k), 12'hC3A});
    end
    chk(16'(o_rx_valid), 16'h0000);
    for (int f = 0; f < 2; f++) begin
      i_format = 2'(f);
      xfer(16'hA5C3, 16'hA5C3);
    end
    i_data_size = 4'h3;
    xfer(16'h00B6, 16'h0006);
    {i_clock_polarity_bit, i_clock_phase_bit, i_data_size} = 6'h3F;
    wr(16'h1234);
    wr(16'h8001);
    rd(16'h1234);
    rd(16'h8001);
    {i_prescale_divisor, i_serial_clock_rate} = 16'h0602;
    wr(16'h0F0F);
    @(posedge o_serial_clock);
    t0 = $time;
    @(posedge o_serial_clock);
    chk(16'(($time - t0) / 10), 16'h0012);
    rd(16'h0F0F);
    idle();
    {i_prescale_divisor, i_serial_clock_rate} = 16'h0200;
    {i_clock_polarity_bit, i_clock_phase_bit, i_loopback} = 3'h0;
    i_data_size = 4'h7;
    xfer(16'h0093, 16'h005A);
    chk(got, 16'h0093);
    i_format = ssp_pkg::FMT_CMD;
    wr(16'h00C5);
    idle();
    final_report();
  end
endmodule // tb
